// ### logic/coef_if.sv
/*
  Interface carrying coefficient writes and reads inside the filter.
  Assumes the filter drives both the write and read sides.
*/
`default_nettype none
interface coef_if;
  import fir_pkg::*;
  logic wr_en;
  logic [COEF_ADDR_W-1:0] wr_addr;
  coef_t wr_data;
  bank_t rd_bank;
  coef_t rd_data [NUM_TAPS];
  modport filt (output wr_en, wr_addr, wr_data, rd_bank, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_bank, output rd_data);
endinterface
`default_nettype wire

// ### logic/coef_mem.sv
/*
  Coefficient store: all banks held at once, one tap row read per cycle.
  Assumes the write port never targets the bank being read.
*/
`default_nettype none
module coef_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Coefficient port
  coef_if.mem cif
);
  import fir_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  coef_t mem_q [NUM_BANKS*NUM_TAPS];
  coef_t rd_q [NUM_TAPS];

  // Writes land in one word; readers of another bank never see them.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_BANKS*NUM_TAPS; i++) begin
        mem_q[i] <= COEF_RESET;
      end
    end else if (cif.wr_en) begin
      mem_q[cif.wr_addr] <= cif.wr_data;
    end
  end

  // Every tap of the selected bank is read in parallel, so switching
  // banks costs one register stage only.
  genvar t;
  generate
    for (t = 0; t < NUM_TAPS; t++) begin : g_rd
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          rd_q[t] <= COEF_RESET;
        end else begin
          rd_q[t] <= mem_q[cif.rd_bank * COEF_ADDR_W'(NUM_TAPS) +
                           COEF_ADDR_W'(t)];
        end
      end
      assign cif.rd_data[t] = rd_q[t];
    end
  endgenerate
endmodule // coef_mem
`default_nettype wire

// ### logic/fir_pkg.sv
/*
  Shared constants and types for the multibank interpolating FIR filter.
  Assumes a single 200 MHz system clock and an asynchronous active-high reset.
*/
`default_nettype none
package fir_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NUM_BANKS = 2;
  localparam int NUM_TAPS = 8;
  localparam int INTERP = 2;
  localparam int NUM_CH = 2;
  localparam int BANK_W = $clog2(NUM_BANKS);
  localparam int TAP_W = $clog2(NUM_TAPS);
  localparam int PHASE_W = $clog2(INTERP);
  localparam int COEF_ADDR_W = $clog2(NUM_BANKS * NUM_TAPS);
  localparam int BUS_ADDR_W = 16;
  // ************************************************************
  // Data widths and offsets
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int COEF_W = 16;
  localparam int ACC_W = DATA_W + COEF_W + TAP_W;
  localparam int OUT_SHIFT = COEF_W - 1;
  localparam logic [BUS_ADDR_W-1:0] COEF_BASE = 16'h0100;
  localparam logic [COEF_W-1:0] COEF_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 1'h0;

  typedef logic [BANK_W-1:0] bank_t;
  typedef logic [COEF_W-1:0] coef_t;
  typedef logic [DATA_W-1:0] data_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_e;
endpackage
`default_nettype wire

// ### logic/multibank_interp_fir.sv
/*
  Multibank interpolating FIR filter: zero-stuffing interpolator with a
  coefficient store of several banks and a coefficient write port.
  Assumes upstream presents one sample slot per INTERP cycles at most and
  that the coefficient writer leaves the selected bank alone.
*/
`default_nettype none
module multibank_interp_fir (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sample input, all channels in one slot
  input wire logic in_valid,
  output logic in_ready,
  input wire fir_pkg::data_t in_data [fir_pkg::NUM_CH],
  input wire fir_pkg::bank_t bank_sel,
  // Sample output, INTERP output slots per input slot
  output logic out_valid,
  output fir_pkg::data_t out_data [fir_pkg::NUM_CH],
  // Coefficient write port
  input wire logic coef_wr,
  input wire logic [fir_pkg::BUS_ADDR_W-1:0] coef_addr,
  input wire fir_pkg::coef_t coef_wdata,
  output logic coef_err
);
  import fir_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  // Tells whether a bus address falls inside the store; the index is formed from rel_addr.
  function automatic logic in_range(input logic [BUS_ADDR_W-1:0] a);
    in_range = (a >= COEF_BASE) &&
      (a < COEF_BASE + BUS_ADDR_W'(NUM_BANKS * NUM_TAPS));
  endfunction

  coef_if cif ();

  logic wr_ok;
  logic [BUS_ADDR_W-1:0] rel_addr;
  // Word index = bank * NUM_TAPS + tap, so the writer computes base +
  // bank * taps + tap and the row/column layout falls out.
  assign rel_addr = coef_addr - COEF_BASE;
  assign wr_ok = coef_wr && in_range(coef_addr);
  assign cif.wr_en = wr_ok;
  assign cif.wr_addr = rel_addr[COEF_ADDR_W-1:0];
  assign cif.wr_data = coef_wdata;
  // Selected bank drives the read port directly; no arbitration with
  // writes exists, so filtering never waits.
  assign cif.rd_bank = bank_sel;

  // ************************************************************
  // Coefficient store
  // ************************************************************
  // The store is written and read in the same cycle without a shared
  // port, which is why a refill never costs the sample path a cycle.
  coef_mem u_mem (
    .clk(clk),
    .reset(reset),
    .cif(cif)
  );

  // Writes landing in the bank under use are still taken, but flagged,
  // since the writer is trusted to keep off it.
  // The upper bits of the store index are the bank number, so they are
  // compared with the select as it stands in the write cycle.
  logic err_q, err_d;
  always_comb begin
    err_d = coef_wr && (!in_range(coef_addr) ||
      rel_addr[TAP_W +: BANK_W] == bank_sel);
  end

  // The flag is a one-cycle pulse per offending write; nothing holds it,
  // so a writer that wants a sticky status has to latch it itself.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end
  assign coef_err = err_q;

  // ************************************************************
  // Sequencer
  // ************************************************************
  run_e st_q, st_d;
  logic [PHASE_W-1:0] ph_q, ph_d;
  data_t dl_q [NUM_CH][NUM_TAPS];
  data_t dl_d [NUM_CH][NUM_TAPS];

  // A new slot is taken on phase zero; the remaining phases emit the
  // zero-stuffed outputs of the same slot.
  // Holding in_ready low on the other phases is what paces upstream.
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    dl_d = dl_q;
    case (st_q)
      ST_IDLE: begin
        if (in_valid) begin
          st_d = ST_RUN;
          ph_d = PHASE_W'(INTERP - 1);
        end
      end
      ST_RUN: begin
        if (ph_q != PHASE_RESET) begin
          ph_d = ph_q - PHASE_W'(1);
        end else if (!in_valid) begin
          st_d = ST_IDLE;
        end else begin
          ph_d = PHASE_W'(INTERP - 1);
        end
      end
      default: begin
        st_d = ST_IDLE;
        ph_d = PHASE_RESET;
      end
    endcase
    if (in_valid && in_ready) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = NUM_TAPS - 1; k > 0; k--) begin
          dl_d[c][k] = dl_q[c][k-1];
        end
        dl_d[c][0] = in_data[c];
      end
    end
  end

  assign in_ready = (st_q == ST_IDLE) || (ph_q == PHASE_RESET);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      ph_q <= PHASE_RESET;
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < NUM_TAPS; k++) begin
          dl_q[c][k] <= DATA_RESET;
        end
      end
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      dl_q <= dl_d;
    end
  end

  // ************************************************************
  // Multiply-accumulate
  // ************************************************************
  // Polyphase: output phase p uses taps p, p+INTERP, ... on the newest
  // samples. The coefficient row arrives one cycle after the sequencer
  // step, so the phase and delay line are registered to stay aligned.
  logic act_q, act_d;
  logic [PHASE_W-1:0] mph_q, mph_d;
  data_t md_q [NUM_CH][NUM_TAPS];
  data_t md_d [NUM_CH][NUM_TAPS];
  data_t od_q [NUM_CH];
  data_t od_d [NUM_CH];
  logic ov_q, ov_d;

  always_comb begin
    act_d = (st_d == ST_RUN);
    mph_d = PHASE_W'(INTERP - 1) - ph_d;
    md_d = dl_d;
  end

  // All channels use the same coefficient row: bank select is shared,
  // so per-channel bank choice cannot happen.
  always_comb begin
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    ov_d = act_q;
    for (int c = 0; c < NUM_CH; c++) begin
      acc = '0;
      for (int j = 0; j < NUM_TAPS / INTERP; j++) begin
        acc = acc + ACC_W'($signed(md_q[c][j]) *
          $signed(cif.rd_data[j*INTERP + int'(mph_q)]));
      end
      od_d[c] = acc[OUT_SHIFT +: DATA_W];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_q <= 1'b0;
      mph_q <= PHASE_RESET;
      ov_q <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        od_q[c] <= DATA_RESET;
        for (int k = 0; k < NUM_TAPS; k++) begin
          md_q[c][k] <= DATA_RESET;
        end
      end
    end else begin
      act_q <= act_d;
      mph_q <= mph_d;
      ov_q <= ov_d;
      od_q <= od_d;
      md_q <= md_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Both outputs come straight from flip-flops, so no glitch escapes.
  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule // multibank_interp_fir
`default_nettype wire

// ### test/coef_writer.sv
/* Model of the coefficient writer: one whole bank, a word per cycle.
   Assumes bank, offs and coefs stay put while busy. */
`default_nettype none
module coef_writer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command
  input wire logic start,
  input wire fir_pkg::bank_t bank,
  input wire integer offs,
  input wire fir_pkg::coef_t coefs [fir_pkg::NUM_TAPS],
  output logic busy,
  // Write port
  output logic coef_wr,
  output logic [fir_pkg::BUS_ADDR_W-1:0] coef_addr,
  output fir_pkg::coef_t coef_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import fir_pkg::*;
  int tap;
  // Idle lines toggle so a stale word is never taken for a fresh one.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      coef_wr <= 1'b0;
      tap <= 0;
      coef_addr <= 16'h0000;
      coef_wdata <= 16'h0000;
    end else if (start || busy) begin
      coef_wr <= 1'b1;
      coef_addr <= COEF_BASE + BUS_ADDR_W'(bank * NUM_TAPS + tap + offs);
      coef_wdata <= coefs[tap];
      busy <= tap < NUM_TAPS - 1;
      tap <= (tap + 1) % NUM_TAPS;
    end else begin
      coef_wr <= 1'b0;
      coef_addr <= ~coef_addr;
      coef_wdata <= ~coef_wdata;
    end
  end
endmodule // coef_writer
`default_nettype wire

// ### test/fir_sva.sv
/* Checker for the filter's top ports.
   Assumes it is bound to each multibank_interp_fir instance. */
`default_nettype none
module fir_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sample and coefficient sides
  input wire logic in_valid,
  input wire logic in_ready,
  input wire fir_pkg::bank_t bank_sel,
  input wire logic out_valid,
  input wire logic coef_wr,
  input wire logic [fir_pkg::BUS_ADDR_W-1:0] coef_addr,
  input wire logic coef_err
);
  timeunit 1ns;
  timeprecision 100ps;
  import fir_pkg::*;
  logic [BUS_ADDR_W-1:0] off;
  logic rng;
  logic hit;
  // An address below base wraps to a huge offset, so one compare covers both.
  assign off = coef_addr - COEF_BASE;
  assign rng = off < BUS_ADDR_W'(NUM_BANKS * NUM_TAPS);
  assign hit = off[TAP_W +: BANK_W] == bank_sel;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_phases;
    out_valid ##1 out_valid;
  endsequence
  chk_take_out: assert property (s_take |-> ##2 s_phases)
    else $error("output phases missing");
  chk_ready_gap: assert property (s_take |=> !in_ready)
    else $error("ready during phase one");
  chk_no_stall: assert property (!in_ready |=> in_ready)
    else $error("ready held low");
  chk_out_cause: assert property ($rose(out_valid) |->
    $past(in_valid && in_ready, 2))
    else $error("output without sample");
  chk_err_range: assert property (coef_wr && !rng |=> coef_err)
    else $error("range error not flagged");
  chk_err_sel: assert property (coef_wr && rng && hit |=> coef_err)
    else $error("selected bank write not flagged");
  chk_err_idle: assert property (coef_wr && rng && !hit |=>
    !coef_err)
    else $error("idle bank write flagged");
  chk_err_cause: assert property (coef_err |-> $past(coef_wr))
    else $error("error without write");
endmodule // fir_sva
bind multibank_interp_fir fir_sva u_sva (.clk(clk), .reset(reset),
  .in_valid(in_valid), .in_ready(in_ready), .bank_sel(bank_sel),
  .out_valid(out_valid), .coef_wr(coef_wr), .coef_addr(coef_addr),
  .coef_err(coef_err));
`default_nettype wire

// ### test/testbench.sv
/* Self-checking bench: random streams while the idle bank is rewritten.
   Assumes the design, package, checker and writer model are compiled. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import fir_pkg::*;
  logic clk = 1'b0;
  logic reset, in_valid, in_ready, out_valid, coef_wr, coef_err, start, busy;
  data_t in_data [NUM_CH];
  data_t out_data [NUM_CH];
  bank_t bank_sel, wbank;
  logic [BUS_ADDR_W-1:0] coef_addr, off;
  coef_t coef_wdata;
  coef_t coefs [NUM_TAPS];
  coef_t mem [NUM_BANKS][NUM_TAPS];
  data_t hist [NUM_CH][NUM_TAPS/INTERP];
  data_t exp_q [$];
  logic err_exp;
  logic [31:0] seed = 32'h0000804C;
  int offs, fails, n_tests, cycles;
  multibank_interp_fir DUT (.clk(clk), .reset(reset), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .bank_sel(bank_sel),
    .out_valid(out_valid), .out_data(out_data), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_wdata(coef_wdata), .coef_err(coef_err));
  coef_writer u_wr (.clk(clk), .reset(reset), .start(start), .bank(wbank),
    .offs(offs), .coefs(coefs), .busy(busy), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_wdata(coef_wdata));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Newest sample meets the lowest tap of its phase.
  function automatic data_t fir(int ch, int p, bank_t b);
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    for (int k = 0; k < NUM_TAPS / INTERP; k++) begin
      acc += signed'(hist[ch][k]) * signed'(mem[b][INTERP * k + p]);
    end
    return acc[DATA_W+OUT_SHIFT-1:OUT_SHIFT];
  endfunction
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Samples with random gaps; data is held while ready is low.
  task automatic burst(int n);
    for (int i = 0; i < n; i++) begin
      in_valid = rnd() % 4 != 0;
      foreach (in_data[c]) in_data[c] = data_t'(rnd());
      @(posedge clk);
      while (!(in_valid && in_ready)) begin
        #1 in_valid = 1'b1;
        @(posedge clk);
      end
      #1;
    end
    in_valid = 1'b0;
  endtask
  task automatic wr(bank_t b, int o);
    foreach (coefs[t]) coefs[t] = coef_t'(rnd());
    wbank = b;
    offs = o;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (NUM_TAPS + 1) @(posedge clk);
    #1;
  endtask
  // Reference model and output comparison, one step per edge.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      chk(1'b0, "timeout");
      end_sim();
    end else if (reset) err_exp = 1'b0;
    else begin
      chk(coef_err === err_exp, "coef_err");
      off = coef_addr - COEF_BASE;
      err_exp = coef_wr && (off >= 16'(NUM_BANKS * NUM_TAPS)
        || off[TAP_W +: BANK_W] == bank_sel);
      if (coef_wr && off < 16'(NUM_BANKS * NUM_TAPS))
        mem[off[TAP_W +: BANK_W]][off[TAP_W-1:0]] = coef_wdata;
      if (out_valid) foreach (out_data[c])
        chk(out_data[c] === exp_q.pop_front(), "out_data");
      if (in_valid && in_ready) begin
        // Shift from the oldest end so no tap is overwritten before use.
        for (int k = NUM_TAPS / INTERP - 1; k >= 0; k--) foreach (hist[c])
          hist[c][k] = k ? hist[c][k-1] : in_data[c];
        for (int p = 0; p < INTERP; p++) foreach (hist[c])
          exp_q.push_back(fir(c, p, bank_sel));
      end
    end
  end
  initial begin
    reset = 1'b1;
    in_valid = 1'b0;
    start = 1'b0;
    bank_sel = '0;
    wbank = '0;
    offs = 0;
    foreach (in_data[c]) in_data[c] = DATA_RESET;
    foreach (coefs[t]) coefs[t] = COEF_RESET;
    foreach (mem[b, t]) mem[b][t] = COEF_RESET;
    for (int k = NUM_TAPS / INTERP - 1; k >= 0; k--) foreach (hist[c])
      hist[c][k] = DATA_RESET;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fork
        burst(12);
        wr(~bank_sel, 0);
      join
      repeat (4) @(posedge clk);
      #1 bank_sel = ~bank_sel;
      repeat (2) @(posedge clk);
      #1;
    end
    wr(bank_sel, 0);
    wr(bank_sel, NUM_BANKS * NUM_TAPS);
    burst(6);
    repeat (4) @(posedge clk);
    chk(exp_q.size() == 0, "outputs lost");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
